// ===== common/spi_flags_pkg.sv
// Constants shared by the serial buffer-status and sampling logic.
// Assumes a byte-wide serial transfer, most significant bit first.
package spi_flags_pkg;

	// ************************************************************
	// Sizes
	// ************************************************************
	localparam int unsigned BYTE_BITS = 8;
	localparam int unsigned BIT_CNT_W = 3;
	localparam int unsigned LEN_W     = 8;

	// ************************************************************
	// Reset values and last bit count
	// ************************************************************
	localparam logic SR_EMPTY_RST = 1'h1;
	localparam logic RX_EMPTY_RST = 1'h1;
	localparam logic [7:0] RX_BUF_RST   = 8'h00;
	localparam logic [2:0] BIT_CNT_RST  = 3'h0;
	localparam logic [2:0] BIT_CNT_LAST = 3'h7;

	// ************************************************************
	// Timing
	// ************************************************************
	// Master samples this many system clock cycles before a bit ends
	localparam logic [7:0] SAMPLE_LEAD_CYC = 8'h01;
	// Smallest bit length the master sampler handles, in cycles
	localparam logic [7:0] MIN_BIT_CYC     = 8'h03;
	// First counter value inside a bit, the start cycle being 0
	localparam logic [7:0] BIT_CNT_FIRST   = 8'h01;

endpackage

// ===== design/spi_slave_link.sv
// Slave receive shifter that runs on the serial clock of the far party.
// Assumes MOSI is stable around the active serial clock edge and that
// the serial clock stands still while the system reset is applied.
`timescale 1ns/1ps

module spi_slave_link (
	// Link clock and reset
	input  wire logic       i_clk_link,
	input  wire logic       i_srst,
	// Serial data
	input  wire logic       i_mosi,
	// Toward the system clock domain
	output logic      [7:0] o_byte,
	output logic            o_byte_tgl,
	output logic            o_edge_tgl
);

	typedef struct packed {
		logic [2:0] bit_cnt;
		logic [7:0] shift;
		logic [7:0] byte_out;
		logic       byte_tgl;
		logic       edge_tgl;
	} link_state_t;

	localparam link_state_t LINK_RST = '{
		bit_cnt:  spi_flags_pkg::BIT_CNT_RST,
		shift:    spi_flags_pkg::RX_BUF_RST,
		byte_out: spi_flags_pkg::RX_BUF_RST,
		byte_tgl: 1'h0,
		edge_tgl: 1'h0
	};

	link_state_t q;
	link_state_t d;

	// ************************************************************
	// Shifter
	// ************************************************************
	// The active serial edge falls in the middle of each bit, so the
	// data is taken there without any oversampling.
	always_comb begin
		d          = q;
		d.shift    = {q.shift[6:0], i_mosi};
		d.bit_cnt  = q.bit_cnt + 3'h1;
		// One edge event per byte: a toggle on every edge would cancel out when
		// several link edges fall inside one system clock period
		if (q.bit_cnt == spi_flags_pkg::BIT_CNT_RST) begin
			d.edge_tgl = ~q.edge_tgl;
		end
		if (q.bit_cnt == spi_flags_pkg::BIT_CNT_LAST) begin
			// Held until the next byte ends, eight edges later at least
			d.byte_out = {q.shift[6:0], i_mosi};
			d.byte_tgl = ~q.byte_tgl;
		end
	end

	// Asynchronous: the serial clock has no edge while reset stands
	always_ff @(posedge i_clk_link or posedge i_srst) begin
		if (i_srst) begin
			q <= LINK_RST;
		end else begin
			q <= d;
		end
	end

	assign o_byte     = q.byte_out;
	assign o_byte_tgl = q.byte_tgl;
	assign o_edge_tgl = q.edge_tgl;

	// ************************************************************
	// Checks
	// ************************************************************
	property p_mosi_mid_bit;
		@(posedge i_clk_link) disable iff (i_srst)
		1'b1 |=> q.shift[0] == $past(i_mosi);
	endproperty
	a_mosi_mid_bit: assert property (p_mosi_mid_bit)
		else $error("MOSI not taken at the serial edge");

	property p_byte_done;
		@(posedge i_clk_link) disable iff (i_srst)
		(q.bit_cnt == spi_flags_pkg::BIT_CNT_LAST)
			|=> (o_byte_tgl != $past(o_byte_tgl)) && (o_byte == $past(d.byte_out));
	endproperty
	a_byte_done: assert property (p_byte_done)
		else $error("Byte completion not signalled after eighth bit");

endmodule // spi_slave_link

// ===== design/spi_flags_sample.sv
// Buffer-status flags and data sampling points of a serial port unit.
// Assumes transmit buffer, mode select and bit timing come from logic on
// the system clock, and the slave serial clock arrives on its own port.
`timescale 1ns/1ps

module spi_flags_sample (
	// System clock and reset
	input  wire logic       i_clk_sys,
	input  wire logic       i_srst,
	// Link clock from the far master
	input  wire logic       i_clk_link,
	// Mode and transmit buffer
	input  wire logic       i_master_mode,
	input  wire logic       i_tx_pending,
	input  wire logic       i_tx_load,
	// Receive buffer access
	input  wire logic       i_rx_read,
	// Master bit timing
	input  wire logic       i_bit_start,
	input  wire logic [7:0] i_bit_cycles,
	// Serial pins
	input  wire logic       i_mosi,
	input  wire logic       i_miso,
	// Status
	output logic            o_shift_reg_empty,
	output logic            o_rx_buf_empty,
	output logic      [7:0] o_rx_data,
	// Master sample stream
	output logic            o_mst_bit,
	output logic            o_mst_bit_vld
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [1:0] byte_sync;
		logic       byte_seen;
		logic [1:0] edge_sync;
		logic       edge_seen;
		logic [1:0] miso_sync;
		logic [7:0] rx_buf;
		logic       rx_empty;
		logic       sr_empty;
		logic       bit_active;
		logic [7:0] bit_cnt;
		logic [2:0] mst_bits;
		logic [7:0] mst_shift;
		logic       mst_bit;
		logic       mst_bit_vld;
	} sys_state_t;

	localparam sys_state_t SYS_RST = '{
		byte_sync:   2'h0,
		byte_seen:   1'h0,
		edge_sync:   2'h0,
		edge_seen:   1'h0,
		miso_sync:   2'h0,
		rx_buf:      spi_flags_pkg::RX_BUF_RST,
		rx_empty:    spi_flags_pkg::RX_EMPTY_RST,
		sr_empty:    spi_flags_pkg::SR_EMPTY_RST,
		bit_active:  1'h0,
		bit_cnt:     8'h00,
		mst_bits:    spi_flags_pkg::BIT_CNT_RST,
		mst_shift:   spi_flags_pkg::RX_BUF_RST,
		mst_bit:     1'h0,
		mst_bit_vld: 1'h0
	};

	sys_state_t q;
	sys_state_t d;

	logic [7:0] link_byte;
	logic       link_byte_tgl;
	logic       link_edge_tgl;
	logic       byte_evt;
	logic       edge_evt;
	logic       sample_now;
	logic       bit_last;
	logic       sr_set;
	logic [7:0] sample_idx;
	logic [7:0] last_idx;

	// A toggle that moved since it was last seen marks one event
	function automatic logic toggle_event(input logic synced, input logic seen);
		return synced ^ seen;
	endfunction

	// ************************************************************
	// Link domain
	// ************************************************************
	spi_slave_link u_link (
		.i_clk_link (i_clk_link),
		.i_srst     (i_srst),
		.i_mosi     (i_mosi),
		.o_byte     (link_byte),
		.o_byte_tgl (link_byte_tgl),
		.o_edge_tgl (link_edge_tgl)
	);

	// ************************************************************
	// Event decode
	// ************************************************************
	// Only second stage flops and the seen flops behind them feed the detectors
	assign byte_evt   = toggle_event(q.byte_sync[1], q.byte_seen);
	assign edge_evt   = toggle_event(q.edge_sync[1], q.edge_seen);
	assign sample_idx = i_bit_cycles - spi_flags_pkg::SAMPLE_LEAD_CYC - 8'h01;
	assign last_idx   = i_bit_cycles - 8'h01;
	assign sample_now = q.bit_active && (q.bit_cnt == sample_idx);
	assign bit_last   = q.bit_active && (q.bit_cnt == last_idx);
	assign sr_set     = byte_evt && !i_tx_pending;

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		d             = q;
		d.byte_sync   = {q.byte_sync[0], link_byte_tgl};
		d.edge_sync   = {q.edge_sync[0], link_edge_tgl};
		d.miso_sync   = {q.miso_sync[0], i_miso};
		d.byte_seen   = q.byte_sync[1];
		d.edge_seen   = q.edge_sync[1];
		d.mst_bit_vld = 1'h0;

		// Master bit timer; the start cycle counts as index 0
		if (i_bit_start) begin
			d.bit_active = 1'h1;
			d.bit_cnt    = spi_flags_pkg::BIT_CNT_FIRST;
		end else if (bit_last) begin
			d.bit_active = 1'h0;
			d.bit_cnt    = 8'h00;
		end else if (q.bit_active) begin
			d.bit_cnt = q.bit_cnt + 8'h01;
		end

		// Late sampling gives the far slave the most settling time
		if (sample_now) begin
			d.mst_bit     = q.miso_sync[1];
			d.mst_bit_vld = 1'h1;
			d.mst_shift   = {q.mst_shift[6:0], q.miso_sync[1]};
			d.mst_bits    = q.mst_bits + 3'h1;
		end

		if (i_master_mode) begin
			d.sr_empty = 1'h1;
			d.rx_empty = 1'h1;
			if (sample_now && (q.mst_bits == spi_flags_pkg::BIT_CNT_LAST)) begin
				d.rx_buf = {q.mst_shift[6:0], q.miso_sync[1]};
			end
		end else begin
			// Set wins: a short frame brings its edge and byte events together
			if (sr_set) begin
				d.sr_empty = 1'h1;
			end else if (i_tx_load || edge_evt) begin
				d.sr_empty = 1'h0;
			end
			// A byte landing with a read keeps the flag low
			if (byte_evt) begin
				d.rx_buf   = link_byte;
				d.rx_empty = 1'h0;
			end else if (i_rx_read) begin
				d.rx_empty = 1'h1;
			end
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			q <= SYS_RST;
		end else begin
			q <= d;
		end
	end

	assign o_shift_reg_empty = q.sr_empty;
	assign o_rx_buf_empty    = q.rx_empty;
	assign o_rx_data         = q.rx_buf;
	assign o_mst_bit         = q.mst_bit;
	assign o_mst_bit_vld     = q.mst_bit_vld;

	// ************************************************************
	// Checks
	// ************************************************************
	property p_sr_master_one;
		@(posedge i_clk_sys) disable iff (i_srst)
		i_master_mode |=> o_shift_reg_empty;
	endproperty
	a_sr_master_one: assert property (p_sr_master_one)
		else $error("Shift empty low in master mode");

	property p_rx_master_one;
		@(posedge i_clk_sys) disable iff (i_srst)
		i_master_mode [*2] |=> o_rx_buf_empty && $stable(o_rx_buf_empty);
	endproperty
	a_rx_master_one: assert property (p_rx_master_one)
		else $error("Receive empty low in master mode");

	property p_sr_set;
		@(posedge i_clk_sys) disable iff (i_srst)
		(!i_master_mode && byte_evt && !i_tx_pending) |=> o_shift_reg_empty;
	endproperty
	a_sr_set: assert property (p_sr_set)
		else $error("Shift empty not set after byte");

	property p_sr_clear;
		@(posedge i_clk_sys) disable iff (i_srst)
		(!i_master_mode && (i_tx_load || edge_evt) && !sr_set) |=> !o_shift_reg_empty;
	endproperty
	a_sr_clear: assert property (p_sr_clear)
		else $error("Shift empty not cleared by load or edge");

	property p_rx_new_byte;
		@(posedge i_clk_sys) disable iff (i_srst)
		(!i_master_mode && byte_evt)
			|=> !o_rx_buf_empty && (o_rx_data == $past(link_byte));
	endproperty
	a_rx_new_byte: assert property (p_rx_new_byte)
		else $error("New byte not flagged in receive buffer");

	property p_rx_read;
		@(posedge i_clk_sys) disable iff (i_srst)
		(!i_master_mode && i_rx_read && !byte_evt) |=> o_rx_buf_empty;
	endproperty
	a_rx_read: assert property (p_rx_read)
		else $error("Receive empty not set after read");

	property p_rx_slave_only;
		@(posedge i_clk_sys) disable iff (i_srst)
		$fell(o_rx_buf_empty) |-> !$past(i_master_mode) && $past(byte_evt);
	endproperty
	a_rx_slave_only: assert property (p_rx_slave_only)
		else $error("Receive empty fell outside slave byte arrival");

	property p_mst_sample;
		@(posedge i_clk_sys) disable iff (i_srst)
		(q.bit_active && (q.bit_cnt == i_bit_cycles - 8'h02) && $stable(i_bit_cycles))
			|=> o_mst_bit_vld && (o_mst_bit == $past(q.miso_sync[1]))
			##1 !o_mst_bit_vld;
	endproperty
	a_mst_sample: assert property (p_mst_sample)
		else $error("MISO not sampled one cycle before bit end");

	property p_mst_sample_only;
		@(posedge i_clk_sys) disable iff (i_srst)
		o_mst_bit_vld |-> $past(q.bit_active) && ($past(q.bit_cnt) + 8'h02 == $past(i_bit_cycles));
	endproperty
	a_mst_sample_only: assert property (p_mst_sample_only)
		else $error("MISO sampled at the wrong point of the bit");

	property p_sr_rise_cause;
		@(posedge i_clk_sys) disable iff (i_srst)
		$rose(o_shift_reg_empty) |-> $past(i_master_mode) || $past(sr_set);
	endproperty
	a_sr_rise_cause: assert property (p_sr_rise_cause)
		else $error("Shift empty rose without byte end or master mode");

	property p_sr_edge_clear;
		@(posedge i_clk_sys) disable iff (i_srst)
		(!i_master_mode && edge_evt && !byte_evt) |=> !o_shift_reg_empty;
	endproperty
	a_sr_edge_clear: assert property (p_sr_edge_clear)
		else $error("Shift empty not cleared by serial edge");

	property p_rx_rise_cause;
		@(posedge i_clk_sys) disable iff (i_srst)
		$rose(o_rx_buf_empty) |-> $past(i_master_mode) || $past(i_rx_read);
	endproperty
	a_rx_rise_cause: assert property (p_rx_rise_cause)
		else $error("Receive empty rose without read or master mode");

	property p_rx_data_hold;
		@(posedge i_clk_sys) disable iff (i_srst)
		(!byte_evt && !sample_now) |=> $stable(o_rx_data);
	endproperty
	a_rx_data_hold: assert property (p_rx_data_hold)
		else $error("Receive buffer changed without a new byte");

	property p_vld_single;
		@(posedge i_clk_sys) disable iff (i_srst)
		o_mst_bit_vld |=> !o_mst_bit_vld;
	endproperty
	a_vld_single: assert property (p_vld_single)
		else $error("Master sample strobe longer than one cycle");

	property p_mst_byte;
		@(posedge i_clk_sys) disable iff (i_srst)
		($past(i_master_mode) && o_mst_bit_vld && (q.mst_bits == spi_flags_pkg::BIT_CNT_RST))
			|-> (o_rx_data[0] == o_mst_bit);
	endproperty
	a_mst_byte: assert property (p_mst_byte)
		else $error("Eighth master sample not placed in receive buffer");

endmodule // spi_flags_sample

// ===== dv/spi_far_model.sv
// Far serial party: master clock and MOSI for slave frames, MISO bits.
// Assumes the bench keeps the unit in the mode that matches its use.
`timescale 1ns/1ps

module spi_far_model (
	// Master bit timing
	input  wire logic i_clk_sys,
	input  wire logic i_bit_start,
	// Serial pins
	output logic      o_clk_link,
	output logic      o_mosi,
	output logic      o_miso
);
	logic [7:0] miso_q;

	initial begin
		o_clk_link = 1'b0;
		o_mosi     = 1'b0;
		o_miso     = 1'b0;
		miso_q     = 8'h00;
	end

	// ************************************************************
	// Frame as far master
	// ************************************************************
	// Clock stands low outside frames; rising edge is bit centre
	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			o_mosi = b[i];
			#3 o_clk_link = 1'b1;
			#3 o_clk_link = 1'b0;
		end
		// Released line: inverse level so a stale bit cannot pass
		o_mosi = ~o_mosi;
	endtask

	// ************************************************************
	// Slave answer on MISO, one bit per master bit
	// ************************************************************
	always @(posedge i_clk_sys) begin
		if (i_bit_start) begin
			o_miso <= miso_q[7];
			miso_q <= {miso_q[6:0], ~miso_q[7]};
		end
	end

endmodule // spi_far_model

// ===== dv/testbench.sv
// Self-checking bench for the serial flag and sampling block.
// Assumes the far model owns link clock, MOSI and MISO.
`timescale 1ns/1ps

module testbench;
	logic       clk_sys = 1'b0;
	logic       srst = 1'b1;
	logic       master_mode = 1'b0;
	logic       tx_pending = 1'b0;
	logic       tx_load = 1'b0;
	logic       rx_read = 1'b0;
	logic       bit_start = 1'b0;
	logic [7:0] bit_cycles = 8'h06;
	logic       clk_link, mosi, miso;
	logic       sr_empty, rx_empty, mst_bit, mst_vld;
	logic [7:0] rx_data, b;
	logic       pend;
	logic       ld;
	logic       sr_prev = 1'b1;
	int         error_cnt = 0;
	int         checked = 0;
	int         c, n;

	always #50 clk_sys = ~clk_sys;

	spi_far_model u_far (.i_clk_sys(clk_sys), .i_bit_start(bit_start),
		.o_clk_link(clk_link), .o_mosi(mosi), .o_miso(miso));

	spi_flags_sample DUT (.i_clk_sys(clk_sys), .i_srst(srst), .i_clk_link(clk_link),
		.i_master_mode(master_mode), .i_tx_pending(tx_pending), .i_tx_load(tx_load),
		.i_rx_read(rx_read), .i_bit_start(bit_start), .i_bit_cycles(bit_cycles),
		.i_mosi(mosi), .i_miso(miso), .o_shift_reg_empty(sr_empty),
		.o_rx_buf_empty(rx_empty), .o_rx_data(rx_data), .o_mst_bit(mst_bit),
		.o_mst_bit_vld(mst_vld));

	// ************************************************************
	// Compare and verdict
	// ************************************************************
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_of_test();
		$display("Errors %0d Checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	function automatic logic [7:0] sr_exp(input logic pending);
		return {7'h00, ~pending};
	endfunction

	// ************************************************************
	// Slave frames, then master sampling
	// ************************************************************
	initial begin
		void'($urandom(32'h6fcc));
		repeat (6) @(posedge clk_sys);
		srst <= 1'b0;
		@(negedge clk_sys);
		check(8'(sr_empty), 8'h01);
		check(8'(rx_empty), 8'h01);
		for (int k = 0; k < 10; k++) begin
			b = 8'($urandom);
			// Corner first: byte pending and no load, so only the edges clear
			pend = (k == 0) ? 1'b1 : 1'($urandom);
			ld = (k == 0) ? 1'b0 : 1'($urandom);
			@(posedge clk_sys);
			tx_pending <= pend;
			tx_load <= ld;
			@(posedge clk_sys);
			tx_load <= 1'b0;
			@(negedge clk_sys);
			check(8'(sr_empty), {7'h00, sr_prev & ~ld});
			// Random phase lets the first edge and the byte end land apart
			#(1.7 + $urandom_range(40, 0)) u_far.send_byte(b);
			for (c = 0; c < 12 && rx_empty !== 1'b0; c++) @(negedge clk_sys);
			check(rx_data, b);
			check(8'(rx_empty), 8'h00);
			check(8'(sr_empty), sr_exp(pend));
			sr_prev = ~pend;
			@(posedge clk_sys);
			rx_read <= 1'b1;
			@(posedge clk_sys);
			rx_read <= 1'b0;
			@(negedge clk_sys);
			check(8'(rx_empty), 8'h01);
		end
		@(posedge clk_sys);
		master_mode <= 1'b1;
		tx_pending <= 1'b0;
		@(negedge clk_sys);
		#1.3 u_far.send_byte(8'($urandom));
		repeat (6) @(negedge clk_sys);
		check(8'(sr_empty), 8'h01);
		check(8'(rx_empty), 8'h01);
		b = 8'($urandom);
		u_far.miso_q = b;
		for (int k = 0; k < 8; k++) begin
			n = $urandom_range(9, 6);
			@(posedge clk_sys);
			bit_start <= 1'b1;
			bit_cycles <= 8'(n);
			@(posedge clk_sys);
			bit_start <= 1'b0;
			c = 1;
			@(negedge clk_sys);
			while (mst_vld !== 1'b1 && c < 12) begin
				@(negedge clk_sys);
				c++;
			end
			check(8'(c), 8'(n - 1));
			check(8'(mst_bit), {7'h00, b[7 - k]});
		end
		repeat (3) @(negedge clk_sys);
		check(rx_data, b);
		check(8'(rx_empty), 8'h01);
		check(8'(sr_empty), 8'h01);
		end_of_test();
	end

	initial begin
		#1_000_000;
		error_cnt++;
		end_of_test();
	end

endmodule // testbench
